// ===== mlic_arbiter.sv
`timescale 1ns/1ns
module mlic_arbiter
  import mlic_pkg::*;
(
  // requests of one level
  input wire logic [NUM_SRC-1:0] req,
  // rotation
  input wire logic rr_en,
  input wire logic [SRC_W-1:0] last,
  // result
  output logic hit,
  output logic [SRC_W-1:0] idx
);
  logic [SRC_W-1:0] k;

  // lowest index means lowest base vector, table is ascending
  always_comb
  begin
    hit = 1'b0;
    idx = '0;
    k = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      // with rotation, search starts just after the last grant
      k = rr_en ? SRC_W'(last + SRC_W'(1) + SRC_W'(i)) : SRC_W'(i);
      if (req[k])
      begin
        hit = 1'b1;
        idx = k;
      end
    end
  end
endmodule

// ===== mlic_core_model.sv
`timescale 1ns/1ns
module mlic_core_model
  import mlic_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // from controller
  input wire logic irq_valid,
  input wire logic [VEC_W-1:0] irq_vector,
  // bench commands
  input wire logic slow,
  input wire logic ret_go,
  // to controller
  output logic core_ack,
  output logic core_reti,
  output logic [VEC_W-1:0] pc_ff
);
  logic [1:0] wait_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_ack <= 1'b0;
      core_reti <= 1'b0;
      pc_ff <= 16'h0000;
      wait_ff <= 2'h0;
    end
    else
    begin
      wait_ff <= irq_valid ? wait_ff + 2'h1 : 2'h0;
      // ack held only until the edge that takes it
      core_ack <= irq_valid && !core_ack && (!slow || wait_ff == 2'h3);
      if (irq_valid && core_ack)
        pc_ff <= irq_vector;
      core_reti <= ret_go;
    end
  end
endmodule

// ===== mlic_ctrl.sv
`timescale 1ns/1ns
module mlic_ctrl
  import mlic_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // peripheral requests and configuration
  input wire logic [NUM_SRC-1:0] IRQ_REQ,
  input wire logic [NUM_SRC*2-1:0] IRQ_LEVEL,
  input wire logic [NUM_SRC*OFS_W-1:0] IRQ_OFFSET,
  input wire logic OSC_FAIL_REQ,
  // controller configuration
  input wire logic LOW_EN,
  input wire logic MED_EN,
  input wire logic HIGH_EN,
  input wire logic RR_EN,
  input wire logic BOOT_VECTORS,
  // core handshake
  input wire logic CORE_ACK,
  input wire logic CORE_RETI,
  // to core
  output logic IRQ_VALID,
  output logic [VEC_W-1:0] IRQ_VECTOR,
  output logic NMI_ACTIVE,
  output logic [NEST_W-1:0] LEVEL_ACTIVE,
  output logic [SRC_W-1:0] GRANT_SRC,
  output logic GRANT_ACK
);
  import mlic_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // fixed base table
  function automatic logic [VEC_W-1:0] src_base(input logic [SRC_W-1:0] s);
    logic [VEC_W-1:0] b;
    b = SPARE_VECTOR_BASE;
    case (s)
      3'h0: b = PORT_C_VECTOR_BASE;
      3'h1: b = PORT_R_VECTOR_BASE;
      3'h2: b = DMA_VECTOR_BASE;
      3'h3: b = WIDE_RTC_VECTOR_BASE;
      3'h4: b = TWO_WIRE_C_VECTOR_BASE;
      3'h5: b = TIMER_C0_VECTOR_BASE;
      default: b = SPARE_VECTOR_BASE;
    endcase
    return b;
  endfunction

  // word address relocated by section choice
  function automatic logic [VEC_W-1:0] place(input logic [VEC_W-1:0] v, input logic boot);
    return boot ? VEC_W'(BOOT_SECTION_BASE + v) : v;
  endfunction

  // ****************************************
  // request sorting
  // ****************************************
  logic [NUM_SRC-1:0] req_low;
  logic [NUM_SRC-1:0] req_med;
  logic [NUM_SRC-1:0] req_high;
  logic hit_low;
  logic hit_med;
  logic hit_high;
  logic [SRC_W-1:0] idx_low;
  logic [SRC_W-1:0] idx_med;
  logic [SRC_W-1:0] idx_high;
  logic [SRC_W-1:0] rr_last_ff;
  logic [SRC_W-1:0] nxt_rr_last;

  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
    begin
      req_low[i] = IRQ_REQ[i] && LOW_EN && (mlic_level_t'(IRQ_LEVEL[i*2 +: 2]) == LVL_LOW);
      req_med[i] = IRQ_REQ[i] && MED_EN && (mlic_level_t'(IRQ_LEVEL[i*2 +: 2]) == LVL_MED);
      req_high[i] = IRQ_REQ[i] && HIGH_EN && (mlic_level_t'(IRQ_LEVEL[i*2 +: 2]) == LVL_HIGH);
    end
  end

  mlic_arbiter u_arb_low
  (
    .req(req_low),
    .rr_en(RR_EN),
    .last(rr_last_ff),
    .hit(hit_low),
    .idx(idx_low)
  );

  mlic_arbiter u_arb_med
  (
    .req(req_med),
    .rr_en(1'b0),
    .last(rr_last_ff),
    .hit(hit_med),
    .idx(idx_med)
  );

  mlic_arbiter u_arb_high
  (
    .req(req_high),
    .rr_en(1'b0),
    .last(rr_last_ff),
    .hit(hit_high),
    .idx(idx_high)
  );

  // ****************************************
  // grant state
  // ****************************************
  mlic_state_t state_ff;
  mlic_state_t nxt_state;
  logic valid_ff;
  logic nxt_valid;
  logic [VEC_W-1:0] vector_ff;
  logic [VEC_W-1:0] nxt_vector;
  logic nmi_ff;
  logic nxt_nmi;
  logic [NEST_W-1:0] active_ff;
  logic [NEST_W-1:0] nxt_active;
  logic [NEST_W-1:0] pend_lvl_ff;
  logic [NEST_W-1:0] nxt_pend_lvl;
  logic pend_nmi_ff;
  logic nxt_pend_nmi;
  logic [SRC_W-1:0] src_ff;
  logic [SRC_W-1:0] nxt_src;
  logic ack_ff;
  logic nxt_ack;
  logic [NEST_W-1:0] top_active;
  logic [NEST_W-1:0] after_reti;
  logic [SRC_W-1:0] pick;
  logic [NEST_W-1:0] pick_lvl;
  logic pick_ok;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_valid = valid_ff;
    nxt_vector = vector_ff;
    nxt_nmi = nmi_ff;
    nxt_active = active_ff;
    nxt_pend_lvl = pend_lvl_ff;
    nxt_pend_nmi = pend_nmi_ff;
    nxt_src = src_ff;
    nxt_ack = 1'b0;
    nxt_rr_last = rr_last_ff;
    pick = idx_low;
    pick_lvl = NEST_LOW;
    pick_ok = 1'b0;
    // handler return pops the highest running level, nmi first
    top_active = active_ff[2] ? NEST_HIGH : (active_ff[1] ? NEST_MED : (active_ff[0] ? NEST_LOW : '0));
    after_reti = active_ff & ~top_active;
    if (CORE_RETI)
    begin
      if (nmi_ff)
      begin
        nxt_nmi = 1'b0;
      end
      else
      begin
        nxt_active = after_reti;
      end
    end
    if (hit_high && !active_ff[2])
    begin
      pick = idx_high;
      pick_lvl = NEST_HIGH;
      pick_ok = 1'b1;
    end
    else if (hit_med && !active_ff[2] && !active_ff[1])
    begin
      pick = idx_med;
      pick_lvl = NEST_MED;
      pick_ok = 1'b1;
    end
    // same or lower level keeps waiting
    else if (hit_low && active_ff == '0)
    begin
      pick = idx_low;
      pick_lvl = NEST_LOW;
      pick_ok = 1'b1;
    end
    case (state_ff)
      ST_IDLE:
      begin
        if (OSC_FAIL_REQ && !nmi_ff)
        begin
          nxt_valid = 1'b1;
          nxt_vector = place(OSC_FAILURE_VECTOR, BOOT_VECTORS);
          nxt_pend_nmi = 1'b1;
          nxt_state = ST_ACK;
        end
        else if (pick_ok && !nmi_ff && !CORE_RETI)
        begin
          nxt_valid = 1'b1;
          // base plus offset, offset zero for single sources
          nxt_vector = place(VEC_W'(src_base(pick) + VEC_W'(IRQ_OFFSET[pick*OFS_W +: OFS_W])), BOOT_VECTORS);
          nxt_src = pick;
          nxt_pend_lvl = pick_lvl;
          nxt_pend_nmi = 1'b0;
          nxt_state = ST_ACK;
        end
      end
      ST_ACK:
      begin
        // core takes the vector into its program counter
        if (CORE_ACK)
        begin
          nxt_valid = 1'b0;
          nxt_ack = 1'b1;
          nxt_state = ST_IDLE;
          if (pend_nmi_ff)
          begin
            nxt_nmi = 1'b1;
          end
          else
          begin
            nxt_active = nxt_active | pend_lvl_ff;
            // last low grant drops to the back
            // pointer only moves while rotating, so fixed order leaves it parked
            if (pend_lvl_ff == NEST_LOW && RR_EN)
            begin
              nxt_rr_last = src_ff;
            end
          end
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_ff <= ST_IDLE;
      valid_ff <= 1'b0;
      vector_ff <= RESET_VECTOR;
      nmi_ff <= 1'b0;
      active_ff <= '0;
      pend_lvl_ff <= '0;
      pend_nmi_ff <= 1'b0;
      src_ff <= '0;
      ack_ff <= 1'b0;
      rr_last_ff <= RR_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
      valid_ff <= nxt_valid;
      vector_ff <= nxt_vector;
      nmi_ff <= nxt_nmi;
      active_ff <= nxt_active;
      pend_lvl_ff <= nxt_pend_lvl;
      pend_nmi_ff <= nxt_pend_nmi;
      src_ff <= nxt_src;
      ack_ff <= nxt_ack;
      rr_last_ff <= nxt_rr_last;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign IRQ_VALID = valid_ff;
  assign IRQ_VECTOR = vector_ff;
  assign NMI_ACTIVE = nmi_ff;
  assign LEVEL_ACTIVE = active_ff;
  assign GRANT_SRC = src_ff;
  assign GRANT_ACK = ack_ff;
endmodule

// ===== mlic_ctrl_properties.sv
`timescale 1ns/1ns
module mlic_ctrl_properties
  import mlic_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // inputs
  input wire logic [NUM_SRC-1:0] IRQ_REQ,
  input wire logic OSC_FAIL_REQ,
  input wire logic BOOT_VECTORS,
  input wire logic CORE_ACK,
  input wire logic CORE_RETI,
  // outputs
  input wire logic IRQ_VALID,
  input wire logic [VEC_W-1:0] IRQ_VECTOR,
  input wire logic NMI_ACTIVE,
  input wire logic [NEST_W-1:0] LEVEL_ACTIVE,
  input wire logic GRANT_ACK
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_taken;
    IRQ_VALID && CORE_ACK;
  endsequence
  sequence s_released;
    GRANT_ACK && !IRQ_VALID ##1 !GRANT_ACK;
  endsequence
  chk_ack_pulse: assert property (s_taken |=> s_released)
    else $error("grant pulse wrong after acknowledge");
  chk_offer_holds: assert property (IRQ_VALID && !CORE_ACK |=> IRQ_VALID && $stable(IRQ_VECTOR))
    else $error("offered vector withdrawn");
  chk_nmi_vector: assert property (OSC_FAIL_REQ && !NMI_ACTIVE && !IRQ_VALID && !GRANT_ACK |=>
    IRQ_VALID && IRQ_VECTOR == OSC_FAILURE_VECTOR + (BOOT_VECTORS ? BOOT_SECTION_BASE : 16'h0000))
    else $error("oscillator failure not offered");
  chk_grant_level: assert property (GRANT_ACK |-> LEVEL_ACTIVE != 3'h0 || NMI_ACTIVE)
    else $error("grant without running level");
  chk_offer_cause: assert property ($rose(IRQ_VALID) |-> $past(OSC_FAIL_REQ) || $past(IRQ_REQ) != 8'h00)
    else $error("offer without request");
  chk_reti_pops: assert property (CORE_RETI && NMI_ACTIVE |=> !NMI_ACTIVE)
    else $error("return did not end nmi");
  chk_high_blocks: assert property ((LEVEL_ACTIVE[2] || NMI_ACTIVE) && !CORE_RETI && !OSC_FAIL_REQ |=>
    !$rose(IRQ_VALID))
    else $error("offer during high handler");
  chk_boot_range: assert property (IRQ_VALID |-> (IRQ_VECTOR >= BOOT_SECTION_BASE) == BOOT_VECTORS)
    else $error("vector in wrong section");
endmodule
bind mlic_ctrl mlic_ctrl_properties mlic_ctrl_properties_i (.CLOCK, .RST_N, .IRQ_REQ, .OSC_FAIL_REQ,
  .BOOT_VECTORS, .CORE_ACK, .CORE_RETI, .IRQ_VALID, .IRQ_VECTOR, .NMI_ACTIVE, .LEVEL_ACTIVE, .GRANT_ACK);

// ===== mlic_ctrl_tb.sv
`timescale 1ns/1ns
module mlic_ctrl_tb;
  import mlic_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [NUM_SRC-1:0] IRQ_REQ = 8'h00;
  logic [NUM_SRC*2-1:0] IRQ_LEVEL = 16'h0000;
  logic [NUM_SRC*OFS_W-1:0] IRQ_OFFSET = 32'h0;
  logic OSC_FAIL_REQ = 1'b0, RR_EN = 1'b0, BOOT_VECTORS = 1'b0, slow = 1'b0, ret_go = 1'b0;
  logic LOW_EN = 1'b1, MED_EN = 1'b1, HIGH_EN = 1'b1;
  logic CORE_ACK, CORE_RETI, IRQ_VALID, NMI_ACTIVE, GRANT_ACK;
  logic [VEC_W-1:0] IRQ_VECTOR, pc;
  logic [NEST_W-1:0] LEVEL_ACTIVE;
  logic [SRC_W-1:0] GRANT_SRC;
  logic [15:0] rnd = 16'h4d8d;
  int err_count = 0;
  int n_tests = 0;
  mlic_ctrl mlic_ctrl_i (.CLOCK, .RST_N, .IRQ_REQ, .IRQ_LEVEL, .IRQ_OFFSET, .OSC_FAIL_REQ, .LOW_EN, .MED_EN,
    .HIGH_EN, .RR_EN, .BOOT_VECTORS, .CORE_ACK, .CORE_RETI, .IRQ_VALID, .IRQ_VECTOR, .NMI_ACTIVE,
    .LEVEL_ACTIVE, .GRANT_SRC, .GRANT_ACK);
  mlic_core_model mlic_core_model_i (.clk(CLOCK), .rst_n(RST_N), .irq_valid(IRQ_VALID), .irq_vector(IRQ_VECTOR),
    .slow, .ret_go, .core_ack(CORE_ACK), .core_reti(CORE_RETI), .pc_ff(pc));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [VEC_W-1:0] exp_vec(int src, logic [OFS_W-1:0] ofs, logic boot);
    logic [VEC_W-1:0] b;
    case (src)
      0: b = PORT_C_VECTOR_BASE;
      1: b = PORT_R_VECTOR_BASE;
      2: b = DMA_VECTOR_BASE;
      3: b = WIDE_RTC_VECTOR_BASE;
      4: b = TWO_WIRE_C_VECTOR_BASE;
      default: b = TIMER_C0_VECTOR_BASE;
    endcase
    return b + ofs + (boot ? BOOT_SECTION_BASE : 16'h0000);
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // spare sources use the spare base, which exp_vec does not give, so their vector is not checked
  task automatic take(int src, logic [VEC_W-1:0] vec, logic [NEST_W-1:0] lvl);
    for (int i = 0; i < 40; i++)
    begin
      @(negedge CLOCK);
      if (IRQ_VALID === 1'b1)
        break;
    end
    check(IRQ_VALID, 1'b1);
    if (src >= 0)
      check(GRANT_SRC, src);
    for (int i = 0; i < 40 && GRANT_ACK !== 1'b1; i++)
      @(negedge CLOCK);
    check(GRANT_ACK, 1'b1);
    if (src < 6)
      check({pc, IRQ_VECTOR}, {vec, vec});
    check(LEVEL_ACTIVE, lvl);
  endtask
  task automatic done_irq(logic [NUM_SRC-1:0] keep, int n);
    repeat (n)
    begin
      @(posedge CLOCK);
      IRQ_REQ <= keep;
      OSC_FAIL_REQ <= 1'b0;
      ret_go <= 1'b1;
      @(posedge CLOCK);
      ret_go <= 1'b0;
      @(posedge CLOCK);
    end
    @(negedge CLOCK);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    forever #50 CLOCK = ~CLOCK;
  end
  initial
  begin
    repeat (5000) @(posedge CLOCK);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    int lv;
    int lo;
    logic [OFS_W-1:0] o;
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(negedge CLOCK);
    check({IRQ_VALID, GRANT_ACK, NMI_ACTIVE, LEVEL_ACTIVE, IRQ_VECTOR}, {6'h00, RESET_VECTOR});
    $display("test reset done");
    for (int s = 0; s < 6; s++)
    begin
      rnd = lfsr(rnd);
      o = (s == 3) ? 4'h0 : rnd[3:0];
      lv = rnd[6:5] % 3 + 1;
      @(posedge CLOCK);
      BOOT_VECTORS <= rnd[4];
      IRQ_OFFSET <= 32'(o) << (s * OFS_W);
      IRQ_LEVEL <= 16'(lv) << (2 * s);
      IRQ_REQ <= 8'h01 << s;
      take(s, exp_vec(s, o, rnd[4]), 3'h1 << (lv - 1));
      done_irq(8'h00, 1);
    end
    $display("test vectors done");
    @(posedge CLOCK);
    BOOT_VECTORS <= 1'b0;
    IRQ_OFFSET <= 32'h0;
    {LOW_EN, MED_EN, HIGH_EN} <= 3'h0;
    OSC_FAIL_REQ <= 1'b1;
    take(-1, OSC_FAILURE_VECTOR, 3'h0);
    check(NMI_ACTIVE, 1'b1);
    done_irq(8'h01, 1);
    @(posedge CLOCK);
    IRQ_LEVEL <= 16'h0001;
    repeat (10) @(negedge CLOCK);
    check(IRQ_VALID, 1'b0);
    $display("test nmi done");
    @(posedge CLOCK);
    {LOW_EN, MED_EN, HIGH_EN} <= 3'h7;
    slow <= 1'b1;
    IRQ_LEVEL <= 16'h0039;
    take(0, PORT_C_VECTOR_BASE, NEST_LOW);
    @(posedge CLOCK);
    IRQ_REQ <= 8'h03;
    take(1, PORT_R_VECTOR_BASE, NEST_LOW | NEST_MED);
    @(posedge CLOCK);
    IRQ_REQ <= 8'h47;
    take(2, DMA_VECTOR_BASE, 3'h7);
    repeat (10) @(negedge CLOCK);
    check(IRQ_VALID, 1'b0);
    done_irq(8'h00, 3);
    check(LEVEL_ACTIVE, 3'h0);
    $display("test preempt done");
    @(posedge CLOCK);
    slow <= 1'b0;
    IRQ_LEVEL <= 16'haaaa;
    repeat (4)
    begin
      rnd = lfsr(rnd);
      lo = 0;
      while (!(rnd[lo] || lo == 5))
        lo++;
      @(posedge CLOCK);
      IRQ_REQ <= rnd[7:0] | 8'h20;
      take(lo, exp_vec(lo, 4'h0, 1'b0), NEST_MED);
      done_irq(8'h00, 1);
    end
    @(posedge CLOCK);
    IRQ_LEVEL <= 16'h5555;
    RR_EN <= 1'b1;
    IRQ_REQ <= 8'hff;
    for (int k = 0; k < 9; k++)
    begin
      take(k % 8, exp_vec(k % 8, 4'h0, 1'b0), NEST_LOW);
      done_irq((k < 8) ? 8'hff : 8'h00, 1);
    end
    $display("test arbitration done");
    tally_and_finish();
  end
endmodule

// ===== mlic_pkg.sv
package mlic_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_SRC = 8;
  localparam int SRC_W = 3;
  localparam int VEC_W = 16;
  localparam int OFS_W = 4;
  localparam int NEST_W = 3;

  // ****************************************
  // vector table, program word addresses
  // ****************************************
  localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
  localparam logic [VEC_W-1:0] OSC_FAILURE_VECTOR = 16'h0002;
  localparam logic [VEC_W-1:0] PORT_C_VECTOR_BASE = 16'h0004;
  localparam logic [VEC_W-1:0] PORT_R_VECTOR_BASE = 16'h0008;
  localparam logic [VEC_W-1:0] DMA_VECTOR_BASE = 16'h000c;
  localparam logic [VEC_W-1:0] WIDE_RTC_VECTOR_BASE = 16'h0014;
  localparam logic [VEC_W-1:0] TWO_WIRE_C_VECTOR_BASE = 16'h0018;
  localparam logic [VEC_W-1:0] TIMER_C0_VECTOR_BASE = 16'h001c;
  localparam logic [VEC_W-1:0] SPARE_VECTOR_BASE = 16'h0040;
  // boot section start, word address; plain default
  localparam logic [VEC_W-1:0] BOOT_SECTION_BASE = 16'h8000;

  // ****************************************
  // levels and states
  // ****************************************
  typedef enum logic [1:0] {LVL_OFF, LVL_LOW, LVL_MED, LVL_HIGH} mlic_level_t;
  localparam logic [NEST_W-1:0] NEST_LOW = 3'h1;
  localparam logic [NEST_W-1:0] NEST_MED = 3'h2;
  localparam logic [NEST_W-1:0] NEST_HIGH = 3'h4;
  localparam logic [SRC_W-1:0] RR_RESET = 3'h7;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK} mlic_state_t;
endpackage
